// ### src/prc_periph_reset_clock.sv
// Behaviour
// RULE1: 8 MHz RC flag sets when stable and enabled
// RULE2: Slow crystal flag sets when stable and enabled
// RULE3: 40 kHz RC flag sets when stable and enabled
// RULE4: Flags hold until software writes clear bit
// RULE5: Fast bus reset register, offset 0x0C, zero
// RULE6: Fast reset bits 14,12,11,10,9 map peripherals
// RULE7: Fast reset bits 6..2 reset ports E..A
// RULE8: Fast reset bit 0 resets remap unit
// RULE9: Software writes reserved bits with reset value
// RULE10: Slow bus reset register, offset 0x10, zero
// RULE11: Slow reset bits 29,28,27: DAC, power, backup
// RULE12: Slow reset bits 26,25 CAN; 22,21 I2C
// RULE13: Slow reset bits 20..17: UARTs, serial ports
// RULE14: Slow reset SPI 15,14, watchdog 11, timers
// RULE15: System clock enable at 0x14, reset 0x14
// RULE16: Bit 4 keeps flash clock in sleep
// RULE17: Bit 2 keeps SRAM clock in sleep
// RULE18: Bits 12,8,6 gate USB, memory, CRC clocks
// RULE19: Bits 1,0 gate DMA controller clocks
// RULE20: Fast bus clock enable at 0x18, zero
// RULE21: Fast enable bits 14,12,11,10,9 gate peripherals
// RULE22: Fast enable bits 6..2 gate ports E..A
// RULE23: Fast enable bit 0 gates remap clock
// RULE24: Bit 10 enables 8 MHz ready interrupt
// RULE25: Gated clocks switch glitch free
// RULE26: Any set flag raises interrupt request

////////////////////////////////////////////////////////////////////////////////

// Glitch-free gate: the enable changes only while the clock is low.
module prc_clock_gate (
  input wire logic clk,        // Source clock.
  input wire logic rstn,       // Asynchronous reset, active low.
  input wire logic enable,     // Requested clock enable.
  output logic gated_clk       // Gated clock.
);

  logic en_low;

  // Enable captured on the falling edge so no truncated high phase occurs.
  // RULE25: falling edge latch
  always_ff @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      en_low <= 1'b0;
    end else begin
      en_low <= enable;
    end
  end

  // The clock passes only while the captured enable is high.
  assign gated_clk = clk & en_low;

endmodule : prc_clock_gate

////////////////////////////////////////////////////////////////////////////////

module prc_periph_reset_clock
  import prc_pkg::*;
(
  input wire logic ref_clk,                       // System bus clock.
  input wire logic rstn,                          // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] avs_address,      // Byte address.
  input wire logic avs_read,                      // Read request.
  input wire logic avs_write,                     // Write request.
  input wire logic [DATA_W-1:0] avs_writedata,    // Write data.
  input wire logic [BE_W-1:0] avs_byteenable,     // Byte lane enables.
  output logic [DATA_W-1:0] avs_readdata,         // Read data.
  output logic avs_waitrequest,                   // Stall until access completes.
  input wire logic int_osc8_stable,               // 8 MHz RC oscillator stable.
  input wire logic slow_xtal_stable,              // Slow crystal oscillator stable.
  input wire logic lowfreq_rc_stable,             // 40 kHz RC oscillator stable.
  input wire logic sleep_mode,                    // Core is in sleep mode.
  output logic clk_ready_irq,                     // Oscillator ready interrupt.
  output logic [DATA_W-1:0] fast_bus_reset_out,   // Fast bus peripheral resets.
  output logic [DATA_W-1:0] slow_bus_reset_out,   // Slow bus peripheral resets.
  output logic [DATA_W-1:0] sys_bus_clk_en_out,   // System bus enable register.
  output logic [DATA_W-1:0] fast_bus_clk_en_out,  // Fast bus enable register.
  output logic [DATA_W-1:0] sys_bus_gated_clk,    // System bus gated clocks.
  output logic [DATA_W-1:0] fast_bus_gated_clk    // Fast bus gated clocks.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [DATA_W-1:0] fast_bus_periph_reset;
  logic [DATA_W-1:0] slow_bus_periph_reset;
  logic [DATA_W-1:0] system_bus_clock_enable;
  logic [DATA_W-1:0] fast_bus_clock_enable;
  logic int_osc8_ready_flag;
  logic slow_xtal_ready_flag;
  logic lowfreq_rc_ready_flag;
  logic int_osc8_ready_irq_en;
  logic slow_xtal_ready_irq_en;
  logic lowfreq_rc_ready_irq_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake and address decode.

  wire req = avs_read | avs_write;
  wire wr_fire = avs_write & ~avs_waitrequest;
  wire hit_int = (avs_address == OFS_CLOCK_READY_INTERRUPT);
  wire hit_fast_rst = (avs_address == OFS_FAST_BUS_PERIPH_RESET);
  wire hit_slow_rst = (avs_address == OFS_SLOW_BUS_PERIPH_RESET);
  wire hit_sys_en = (avs_address == OFS_SYSTEM_BUS_CLOCK_ENABLE);
  wire hit_fast_en = (avs_address == OFS_FAST_BUS_CLOCK_ENABLE);

  // Byte enables widened to a bit mask.
  wire [DATA_W-1:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Merge helper: only enabled lanes and writable bits change.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_val,
                                              input logic [DATA_W-1:0] new_val,
                                              input logic [DATA_W-1:0] lanes,
                                              input logic [DATA_W-1:0] wmask);
    logic [DATA_W-1:0] sel;
    sel = lanes & wmask;
    merge = (old_val & ~sel) | (new_val & sel);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // Next values of the control registers.

  // RULE9: reserved bits forced
  // RULE5: fast reset write
  wire [DATA_W-1:0] next_fast_bus_periph_reset = (wr_fire & hit_fast_rst) ?
      merge(fast_bus_periph_reset, avs_writedata, be_mask, MASK_FAST_BUS) :
      fast_bus_periph_reset;

  // RULE10: slow reset write
  wire [DATA_W-1:0] next_slow_bus_periph_reset = (wr_fire & hit_slow_rst) ?
      merge(slow_bus_periph_reset, avs_writedata, be_mask, MASK_SLOW_BUS) :
      slow_bus_periph_reset;

  // RULE15: system enable write
  wire [DATA_W-1:0] next_system_bus_clock_enable = (wr_fire & hit_sys_en) ?
      merge(system_bus_clock_enable, avs_writedata, be_mask, MASK_SYSTEM_BUS) :
      system_bus_clock_enable;

  // RULE20: fast enable write
  wire [DATA_W-1:0] next_fast_bus_clock_enable = (wr_fire & hit_fast_en) ?
      merge(fast_bus_clock_enable, avs_writedata, be_mask, MASK_FAST_BUS) :
      fast_bus_clock_enable;

  // Interrupt enable and clear strobes of the clock ready register.
  wire int_en_wr = wr_fire & hit_int & avs_byteenable[IRQ_EN_BYTE_LANE];
  wire int_clr_wr = wr_fire & hit_int & avs_byteenable[CLR_BYTE_LANE];

  // RULE24: interrupt enable write
  wire next_int_osc8_ready_irq_en = int_en_wr ? avs_writedata[IRQ_EN_INT_OSC8] :
                                                int_osc8_ready_irq_en;
  wire next_slow_xtal_ready_irq_en = int_en_wr ? avs_writedata[IRQ_EN_SLOW_XTAL] :
                                                 slow_xtal_ready_irq_en;
  wire next_lowfreq_rc_ready_irq_en = int_en_wr ? avs_writedata[IRQ_EN_LOWFREQ_RC] :
                                                  lowfreq_rc_ready_irq_en;

  // Clear strobes; the matching bits always read as zero.
  wire int_osc8_ready_flag_clr = int_clr_wr & avs_writedata[CLR_INT_OSC8];
  wire slow_xtal_ready_flag_clr = int_clr_wr & avs_writedata[CLR_SLOW_XTAL];
  wire lowfreq_rc_ready_flag_clr = int_clr_wr & avs_writedata[CLR_LOWFREQ_RC];

  // Set conditions; a set in the same cycle as a clear wins.
  // RULE1: 8 MHz set
  wire int_osc8_set = int_osc8_stable & int_osc8_ready_irq_en;
  // RULE2: crystal set
  wire slow_xtal_set = slow_xtal_stable & slow_xtal_ready_irq_en;
  // RULE3: 40 kHz set
  wire lowfreq_rc_set = lowfreq_rc_stable & lowfreq_rc_ready_irq_en;

  // RULE4: sticky until cleared
  wire next_int_osc8_ready_flag = int_osc8_set |
                                  (int_osc8_ready_flag & ~int_osc8_ready_flag_clr);
  wire next_slow_xtal_ready_flag = slow_xtal_set |
                                   (slow_xtal_ready_flag & ~slow_xtal_ready_flag_clr);
  wire next_lowfreq_rc_ready_flag = lowfreq_rc_set |
                                    (lowfreq_rc_ready_flag & ~lowfreq_rc_ready_flag_clr);

  // RULE26: interrupt from flags
  wire next_clk_ready_irq = next_int_osc8_ready_flag | next_slow_xtal_ready_flag |
                            next_lowfreq_rc_ready_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data selection.

  wire [DATA_W-1:0] int_read_word = {
      21'h00_0000,
      int_osc8_ready_irq_en, slow_xtal_ready_irq_en, lowfreq_rc_ready_irq_en,
      5'h00,
      int_osc8_ready_flag, slow_xtal_ready_flag, lowfreq_rc_ready_flag};

  // Unmapped addresses read as zero.
  wire [DATA_W-1:0] next_readdata =
      hit_int ? int_read_word :
      hit_fast_rst ? fast_bus_periph_reset :
      hit_slow_rst ? slow_bus_periph_reset :
      hit_sys_en ? system_bus_clock_enable :
      hit_fast_en ? fast_bus_clock_enable :
      ZERO_WORD;

  // Waitrequest drops for one cycle, one cycle after a request is seen.
  wire next_waitrequest = ~(req & avs_waitrequest);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave registers.

  // Handshake and read data capture.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= ZERO_WORD;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset and clock enable registers.

  // RULE5: fast reset storage
  // RULE10: slow reset storage
  // RULE15: system enable storage
  // RULE20: fast enable storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fast_bus_periph_reset <= RST_FAST_BUS_PERIPH_RESET;
      slow_bus_periph_reset <= RST_SLOW_BUS_PERIPH_RESET;
      system_bus_clock_enable <= RST_SYSTEM_BUS_CLOCK_ENABLE;
      fast_bus_clock_enable <= RST_FAST_BUS_CLOCK_ENABLE;
    end else begin
      fast_bus_periph_reset <= next_fast_bus_periph_reset;
      slow_bus_periph_reset <= next_slow_bus_periph_reset;
      system_bus_clock_enable <= next_system_bus_clock_enable;
      fast_bus_clock_enable <= next_fast_bus_clock_enable;
    end
  end

  // Output copies of the reset and enable registers.
  // RULE6: fast reset lines
  // RULE7: port reset lines
  // RULE8: remap reset line
  // RULE11: slow reset lines
  // RULE12: CAN and I2C resets
  // RULE13: serial reset lines
  // RULE14: SPI, watchdog, timers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fast_bus_reset_out <= RST_FAST_BUS_PERIPH_RESET;
      slow_bus_reset_out <= RST_SLOW_BUS_PERIPH_RESET;
      sys_bus_clk_en_out <= RST_SYSTEM_BUS_CLOCK_ENABLE;
      fast_bus_clk_en_out <= RST_FAST_BUS_CLOCK_ENABLE;
    end else begin
      fast_bus_reset_out <= next_fast_bus_periph_reset;
      slow_bus_reset_out <= next_slow_bus_periph_reset;
      sys_bus_clk_en_out <= next_system_bus_clock_enable;
      fast_bus_clk_en_out <= next_fast_bus_clock_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock ready interrupt register.

  // Flags, enables and the interrupt request.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      int_osc8_ready_flag <= RST_CLOCK_READY_INTERRUPT[FLAG_INT_OSC8];
      slow_xtal_ready_flag <= RST_CLOCK_READY_INTERRUPT[FLAG_SLOW_XTAL];
      lowfreq_rc_ready_flag <= RST_CLOCK_READY_INTERRUPT[FLAG_LOWFREQ_RC];
      int_osc8_ready_irq_en <= RST_CLOCK_READY_INTERRUPT[IRQ_EN_INT_OSC8];
      slow_xtal_ready_irq_en <= RST_CLOCK_READY_INTERRUPT[IRQ_EN_SLOW_XTAL];
      lowfreq_rc_ready_irq_en <= RST_CLOCK_READY_INTERRUPT[IRQ_EN_LOWFREQ_RC];
      clk_ready_irq <= 1'b0;
    end else begin
      int_osc8_ready_flag <= next_int_osc8_ready_flag;
      slow_xtal_ready_flag <= next_slow_xtal_ready_flag;
      lowfreq_rc_ready_flag <= next_lowfreq_rc_ready_flag;
      int_osc8_ready_irq_en <= next_int_osc8_ready_irq_en;
      slow_xtal_ready_irq_en <= next_slow_xtal_ready_irq_en;
      lowfreq_rc_ready_irq_en <= next_lowfreq_rc_ready_irq_en;
      clk_ready_irq <= next_clk_ready_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gated peripheral clocks.

  // Sleep-mode bits keep their clock only while awake or when set.
  // RULE16: flash sleep clock
  // RULE17: SRAM sleep clock
  // RULE18: USB, memory, CRC gates
  // RULE19: DMA gates
  wire [DATA_W-1:0] sleep_kill_mask = sleep_mode ? ZERO_WORD : (MASK_SYSTEM_BUS &
      ((ZERO_WORD | (1 << SYS_FLASH_CTRL_SLEEP)) | (ZERO_WORD | (1 << SYS_SRAM_IF_SLEEP))));
  wire [DATA_W-1:0] sys_gate_en = sys_bus_clk_en_out | sleep_kill_mask;

  // One glitch-free gate per bit of both enable registers.
  // RULE21: fast peripheral gates
  // RULE22: port clock gates
  // RULE23: remap clock gate
  // RULE25: gate per clock
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_gate
      prc_clock_gate u_sys_gate (
        .clk(ref_clk),
        .rstn(rstn),
        .enable(sys_gate_en[gi]),
        .gated_clk(sys_bus_gated_clk[gi])
      );
      prc_clock_gate u_fast_gate (
        .clk(ref_clk),
        .rstn(rstn),
        .enable(fast_bus_clk_en_out[gi]),
        .gated_clk(fast_bus_gated_clk[gi])
      );
    end
  endgenerate

endmodule : prc_periph_reset_clock

// ### src/prc_pkg.sv
package prc_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Register byte offsets.
  localparam logic [7:0] OFS_CLOCK_READY_INTERRUPT = 8'h08;
  localparam logic [7:0] OFS_FAST_BUS_PERIPH_RESET = 8'h0C;
  localparam logic [7:0] OFS_SLOW_BUS_PERIPH_RESET = 8'h10;
  localparam logic [7:0] OFS_SYSTEM_BUS_CLOCK_ENABLE = 8'h14;
  localparam logic [7:0] OFS_FAST_BUS_CLOCK_ENABLE = 8'h18;

  // Reset values.
  localparam logic [31:0] RST_CLOCK_READY_INTERRUPT = 32'h0000_0000;
  localparam logic [31:0] RST_FAST_BUS_PERIPH_RESET = 32'h0000_0000;
  localparam logic [31:0] RST_SLOW_BUS_PERIPH_RESET = 32'h0000_0000;
  localparam logic [31:0] RST_SYSTEM_BUS_CLOCK_ENABLE = 32'h0000_0014;
  localparam logic [31:0] RST_FAST_BUS_CLOCK_ENABLE = 32'h0000_0000;

  // Writable bit masks; all other bits are reserved and read as zero.
  localparam logic [31:0] MASK_FAST_BUS = 32'h0000_5E7D;
  localparam logic [31:0] MASK_SLOW_BUS = 32'h3E7E_C83F;
  localparam logic [31:0] MASK_SYSTEM_BUS = 32'h0000_1157;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Clock ready interrupt register fields.
  localparam int FLAG_LOWFREQ_RC = 0;
  localparam int FLAG_SLOW_XTAL = 1;
  localparam int FLAG_INT_OSC8 = 2;
  localparam int IRQ_EN_LOWFREQ_RC = 8;
  localparam int IRQ_EN_SLOW_XTAL = 9;
  localparam int IRQ_EN_INT_OSC8 = 10;
  localparam int CLR_LOWFREQ_RC = 16;
  localparam int CLR_SLOW_XTAL = 17;
  localparam int CLR_INT_OSC8 = 18;
  localparam int CLR_BYTE_LANE = 2;
  localparam int IRQ_EN_BYTE_LANE = 1;

  // Sleep-mode clock enable bits of the system bus register.
  localparam int SYS_FLASH_CTRL_SLEEP = 4;
  localparam int SYS_SRAM_IF_SLEEP = 2;

endpackage : prc_pkg

// ### testbench/prc_periph_reset_clock_assertions.sv
module prc_periph_reset_clock_assertions
  import prc_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic rstn, // Reset.
  input wire logic [ADDR_W-1:0] avs_address, // Address.
  input wire logic avs_read, // Read.
  input wire logic avs_write, // Write.
  input wire logic [DATA_W-1:0] avs_writedata, // Write data.
  input wire logic [BE_W-1:0] avs_byteenable, // Lanes.
  input wire logic [DATA_W-1:0] avs_readdata, // Read data.
  input wire logic avs_waitrequest, // Stall.
  input wire logic int_osc8_stable, // Stable.
  input wire logic slow_xtal_stable, // Stable.
  input wire logic lowfreq_rc_stable, // Stable.
  input wire logic sleep_mode, // Sleep.
  input wire logic clk_ready_irq, // Interrupt.
  input wire logic [DATA_W-1:0] fast_bus_reset_out, // Resets.
  input wire logic [DATA_W-1:0] slow_bus_reset_out, // Resets.
  input wire logic [DATA_W-1:0] sys_bus_clk_en_out, // Enables.
  input wire logic [DATA_W-1:0] fast_bus_clk_en_out, // Enables.
  input wire logic [DATA_W-1:0] sys_bus_gated_clk, // Clocks.
  input wire logic [DATA_W-1:0] fast_bus_gated_clk // Clocks.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Completed accesses, full word and to the flag register.
  wire logic done_wr;
  wire logic done_int;
  assign done_wr = avs_write && !avs_waitrequest && (avs_byteenable == 4'hF);
  assign done_int = avs_write && !avs_waitrequest && (avs_address == OFS_CLOCK_READY_INTERRUPT);
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer to request");
  property p_fast_rst;
    done_wr && avs_address == OFS_FAST_BUS_PERIPH_RESET |=>
      fast_bus_reset_out == ($past(avs_writedata) & MASK_FAST_BUS);
  endproperty
  a_fast_rst: assert property (p_fast_rst) else $error("fast reset write");
  property p_slow_rst;
    done_wr && avs_address == OFS_SLOW_BUS_PERIPH_RESET |=>
      slow_bus_reset_out == ($past(avs_writedata) & MASK_SLOW_BUS);
  endproperty
  a_slow_rst: assert property (p_slow_rst) else $error("slow reset write");
  property p_sys_en;
    done_wr && avs_address == OFS_SYSTEM_BUS_CLOCK_ENABLE |=>
      sys_bus_clk_en_out == ($past(avs_writedata) & MASK_SYSTEM_BUS);
  endproperty
  a_sys_en: assert property (p_sys_en) else $error("system enable write");
  property p_fast_en;
    done_wr && avs_address == OFS_FAST_BUS_CLOCK_ENABLE |=>
      fast_bus_clk_en_out == ($past(avs_writedata) & MASK_FAST_BUS);
  endproperty
  a_fast_en: assert property (p_fast_en) else $error("fast enable write");
  property p_irq_rise;
    $rose(clk_ready_irq) |-> $past(int_osc8_stable | slow_xtal_stable | lowfreq_rc_stable);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without stable");
  property p_irq_fall;
    $fell(clk_ready_irq) |-> $past(done_int);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
  property p_gate_fast;
    @(negedge ref_clk) disable iff (!rstn) $past(rstn) |->
      (fast_bus_gated_clk == $past(fast_bus_clk_en_out)) &&
      ((sys_bus_gated_clk & ~32'h14) == ($past(sys_bus_clk_en_out) & ~32'h14));
  endproperty
  a_gate_fast: assert property (p_gate_fast) else $error("gated clock wrong");
  property p_gate_sleep;
    @(negedge ref_clk) disable iff (!rstn) $past(rstn) |->
      sys_bus_gated_clk[4] == $past(sys_bus_clk_en_out[4] | !sleep_mode) &&
      sys_bus_gated_clk[2] == $past(sys_bus_clk_en_out[2] | !sleep_mode);
  endproperty
  a_gate_sleep: assert property (p_gate_sleep) else $error("sleep clock wrong");
  c_wr: cover property (done_wr);
  c_irq: cover property ($rose(clk_ready_irq));
  c_clr: cover property ($fell(clk_ready_irq));
endmodule : prc_periph_reset_clock_assertions

bind prc_periph_reset_clock prc_periph_reset_clock_assertions u_chk (.ref_clk, .rstn,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .int_osc8_stable, .slow_xtal_stable, .lowfreq_rc_stable, .sleep_mode,
  .clk_ready_irq, .fast_bus_reset_out, .slow_bus_reset_out, .sys_bus_clk_en_out,
  .fast_bus_clk_en_out, .sys_bus_gated_clk, .fast_bus_gated_clk);

// ### testbench/prc_periph_model.sv
module prc_periph_model (
  input wire logic [31:0] fast_bus_gated_clk, // Fast bus clocks.
  input wire logic [31:0] sys_bus_gated_clk, // System bus clocks.
  input wire logic [31:0] fast_bus_reset_out, // Fast bus resets.
  output logic [15:0] fast_ticks [32], // Edges seen per fast peripheral.
  output logic [15:0] sys_ticks [32] // Edges seen per system unit.
);
  timeunit 1ns;
  timeprecision 1ps;
  for (genvar i = 0; i < 32; i++) begin : g_unit
    logic [15:0] n_fast = 16'h0;
    logic [15:0] n_sys = 16'h0;
    // a held reset freezes the peripheral at zero.
    always @(posedge fast_bus_gated_clk[i] or posedge fast_bus_reset_out[i]) begin
      if (fast_bus_reset_out[i]) begin
        n_fast <= 16'h0;
      end else begin
        n_fast <= n_fast + 16'h1;
      end
    end
    // Each system unit counts the clock edges that reach it.
    always @(posedge sys_bus_gated_clk[i]) begin
      n_sys <= n_sys + 16'h1;
    end
    assign fast_ticks[i] = n_fast;
    assign sys_ticks[i] = n_sys;
  end
endmodule : prc_periph_model

// ### testbench/tb_top.sv
module tb_top;
  import prc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, fast_bus_reset_out, slow_bus_reset_out, sys_bus_clk_en_out;
  logic [31:0] fast_bus_clk_en_out, sys_bus_gated_clk, fast_bus_gated_clk;
  logic avs_waitrequest, clk_ready_irq;
  logic [2:0] osc = 3'h0;
  logic sleep_mode = 1'h0;
  logic [15:0] fast_ticks [32];
  logic [15:0] sys_ticks [32];
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  prc_periph_reset_clock uut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .int_osc8_stable(osc[2]), .slow_xtal_stable(osc[1]), .lowfreq_rc_stable(osc[0]),
    .sleep_mode, .clk_ready_irq, .fast_bus_reset_out, .slow_bus_reset_out,
    .sys_bus_clk_en_out, .fast_bus_clk_en_out, .sys_bus_gated_clk, .fast_bus_gated_clk);
  prc_periph_model u_far (.fast_bus_gated_clk, .sys_bus_gated_clk, .fast_bus_reset_out,
    .fast_ticks, .sys_ticks);
  // Clock generator and hang guard.
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One bus access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rdat);
    @(posedge ref_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
    rdat = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    #1;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus(1'h1, a, wd, be, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'h0, a, 32'h0, 4'hF, d);
    check(d, exp);
  endtask : rdchk
  function automatic logic [31:0] out_of(input logic [7:0] a);
    case (a)
      8'h0C: return fast_bus_reset_out;
      8'h10: return slow_bus_reset_out;
      8'h14: return sys_bus_clk_en_out;
      default: return fast_bus_clk_en_out;
    endcase
  endfunction : out_of
  task automatic t_resets();
    rdchk(8'h08, 32'h0);
    rdchk(8'h0C, 32'h0);
    rdchk(8'h10, 32'h0);
    rdchk(8'h14, 32'h14);
    rdchk(8'h18, 32'h0);
    rdchk(8'h40, 32'h0);
    check(sys_bus_clk_en_out, 32'h14);
  endtask : t_resets
  // Walk a one through every writable bit; reserved bits are only ever written as zero.
  task automatic t_walk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] rv);
    for (int b = 0; b < 32; b++) begin
      if (m[b]) begin
        wr(a, 32'h1 << b, 4'hF);
        check(out_of(a), (32'h1 << b) & m);
        rdchk(a, (32'h1 << b) & m);
      end
    end
    wr(a, rv, 4'hF);
  endtask : t_walk
  // Write a whole enable or reset word, then count the edges that reach unit u.
  task automatic t_gate(input logic [7:0] a, input logic [31:0] w, input int u,
                        input logic sys, input logic [15:0] n);
    logic [15:0] s;
    wr(a, w, 4'hF);
    repeat (2) @(posedge ref_clk);
    #1 s = sys ? sys_ticks[u] : fast_ticks[u];
    repeat (8) @(posedge ref_clk);
    #1 check(32'((sys ? sys_ticks[u] : fast_ticks[u]) - s), 32'(n));
  endtask : t_gate
  task automatic t_flags();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      osc[i] <= 1'h1;
      repeat (2) @(posedge ref_clk);
      osc[i] <= 1'h0;
      rdchk(8'h08, 32'h0);
      wr(8'h08, 32'h100 << i, 4'h2);
      @(posedge ref_clk);
      osc[i] <= 1'h1;
      @(posedge ref_clk);
      osc[i] <= 1'h0;
      repeat (4) @(posedge ref_clk);
      rdchk(8'h08, (32'h100 << i) | (32'h1 << i));
      check(32'(clk_ready_irq), 32'h1);
      wr(8'h08, 32'h10000 << i, 4'h4);
      rdchk(8'h08, 32'h100 << i);
      check(32'(clk_ready_irq), 32'h0);
      wr(8'h08, 32'h0, 4'h2);
    end
  endtask : t_flags
  // Main sequence.
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'h1;
    t_resets();
    t_walk(8'h0C, 32'h5E7D, 32'h0);
    t_walk(8'h10, 32'h3E7EC83F, 32'h0);
    t_walk(8'h14, 32'h1157, 32'h14);
    t_walk(8'h18, 32'h5E7D, 32'h0);
    t_gate(8'h18, 32'h4000, 14, 1'h0, 16'h8);
    t_gate(8'h0C, 32'h4000, 14, 1'h0, 16'h0);
    t_gate(8'h14, 32'h1000, 12, 1'h1, 16'h8);
    t_gate(8'h14, 32'h0, 4, 1'h1, 16'h8);
    t_gate(8'h14, 32'h0, 2, 1'h1, 16'h8);
    @(posedge ref_clk);
    sleep_mode <= 1'h1;
    t_gate(8'h14, 32'h1, 0, 1'h1, 16'h8);
    t_gate(8'h14, 32'h0, 0, 1'h1, 16'h0);
    t_gate(8'h14, 32'h1, 4, 1'h1, 16'h0);
    t_gate(8'h14, 32'h10, 4, 1'h1, 16'h8);
    t_gate(8'h14, 32'h1, 2, 1'h1, 16'h0);
    t_gate(8'h14, 32'h4, 2, 1'h1, 16'h8);
    @(posedge ref_clk);
    sleep_mode <= 1'h0;
    wr(8'h14, 32'h14, 4'hF);
    t_flags();
    final_report();
  end
endmodule : tb_top
